// >>> srs_map.vh
// Purpose: constants of the scale range selector (offsets, fields, resets)
// Assumes: weights are counts of 0.0001 unit, interval codes index 1-2-5
// Notes: definitions only, no logic
`ifndef SRS_MAP_VH
`define SRS_MAP_VH

// ==========================================================
// register byte offsets on the axi4-lite bus
`define SRS_A_MODE 8'h00
`define SRS_A_ICODE 8'h04
`define SRS_A_CAPL 8'h08
`define SRS_A_CAPM 8'h0c
`define SRS_A_CAPH 8'h10
`define SRS_A_RES 8'h14
`define SRS_A_ADAPT 8'h18
`define SRS_A_STAT 8'h1c
`define SRS_A_TARE 8'h20
`define SRS_A_NET 8'h24

// ==========================================================
// field positions
`define SRS_F_NR 1:0
`define SRS_F_NI 3:2
`define SRS_F_C0 4:0
`define SRS_F_C1 12:8
`define SRS_F_C2 20:16
`define SRS_F_MW 2:0
`define SRS_F_MC 7:4
`define SRS_F_AZ 10:8
`define SRS_F_PZ 15:12
`define SRS_F_OV 23:16

// ==========================================================
// reset values
`define SRS_MODE_RST 32'h00000005
`define SRS_ICODE_RST 32'h000d0c0b
`define SRS_CAPL_RST 32'h00e4e1c0
`define SRS_CAPM_RST 32'h01c9c380
`define SRS_CAPH_RST 32'h03938700
`define SRS_RES_RST 16'h0bb8
`define SRS_ADAPT_RST 32'h00092171

// ==========================================================
// interval codes and misc
`define SRS_CODE_MAX 5'h11
`define SRS_CODE_STEP 5'h01
`define SRS_CODE_STEP2 5'h02
`define SRS_RNG_LOW 2'h0
`define SRS_RNG_MID 2'h1
`define SRS_RNG_HIGH 2'h2
`define SRS_CNT_ONE 2'h1
`define SRS_CNT_TWO 2'h2
`define SRS_CNT_THREE 2'h3
`define SRS_RESP_OKAY 2'h0
`define SRS_RESP_SLVERR 2'h2

`endif

// >>> srs_itab.v
// Purpose: interval table, three read ports with registered data
// Assumes: codes 0..17 map to 0.0001 .. 50 in 1-2-5 steps
// Notes: value is given in counts of 0.0001 unit
`timescale 1ns/100ps
`include "srs_map.vh"

module srs_itab (
	input wire aclk,
	input wire aresetn,
	input wire [14:0] code, // three packed 5-bit codes
	output wire [95:0] ival // three packed 32-bit intervals
);
	// ==========================================================
	// table lookup
	function [31:0] iv_of;
		input [4:0] c;
		begin
			case (c)
			5'h00: iv_of = 32'h00000001;
			5'h01: iv_of = 32'h00000002;
			5'h02: iv_of = 32'h00000005;
			5'h03: iv_of = 32'h0000000a;
			5'h04: iv_of = 32'h00000014;
			5'h05: iv_of = 32'h00000032;
			5'h06: iv_of = 32'h00000064;
			5'h07: iv_of = 32'h000000c8;
			5'h08: iv_of = 32'h000001f4;
			5'h09: iv_of = 32'h000003e8;
			5'h0a: iv_of = 32'h000007d0;
			5'h0b: iv_of = 32'h00001388;
			5'h0c: iv_of = 32'h00002710;
			5'h0d: iv_of = 32'h00004e20;
			5'h0e: iv_of = 32'h0000c350;
			5'h0f: iv_of = 32'h000186a0;
			5'h10: iv_of = 32'h00030d40;
			// codes past the top clamp to the largest interval
			default: iv_of = 32'h0007a120;
			endcase
		end
	endfunction

	// ==========================================================
	// registered read ports
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_port
			reg [31:0] q; // registered read data
			always @(posedge aclk) begin
				if (!aresetn) begin
					q <= 32'h00000001;
				end else begin
					q <= iv_of(code[i*5 +: 5]);
				end
			end
			assign ival[i*32 +: 32] = q;
		end
	endgenerate
endmodule

// >>> srs_top.v
// Purpose: picks active weighing range and interval per weight sample
// Assumes: gross_weight comes on the same clock, tare_key is a raw pin
// Notes: configuration and status over axi4-lite, 32-bit words
`timescale 1ns/100ps
`include "srs_map.vh"

// How it works
// R1: single, dual or triple range, own capacity
// R2: loading steps range up to next one
// R3: unloading keeps the higher range reached
// R4: net at zero waits for tare key clear
// R5: gross zero load returns to smallest range
// R6: range step rounds stored tare to interval
// R7: software keeps equal decimals in all ranges
// R8: software keeps increments within cell resolution
// R9: single range may use two/three intervals
// R10: interval follows weight both directions
// R11: tared multi-interval shows smallest interval
// R12: tare limited to smallest interval range
// R13: only smallest range configured, rest derived
// R14: first limit is interval times resolution
// R15: next interval next code, limit times resolution
// R16: adaptation defaults set at reset
// R17: intervals follow 1-2-5 from 0.0001 to 50
// R18: motion window code 0..4 encoding
// R19: decide once per sample, first exceeding steps
// R20: range, interval and decimals go with sample
module srs_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sample_valid, // one-cycle strobe with a new gross weight
	input wire [31:0] gross_weight, // signed, counts of 0.0001 unit
	input wire tare_key, // raw operator key, high while pressed
	output reg out_valid, // one cycle after each sample
	output reg [1:0] out_range, // active range or interval range
	output reg [4:0] out_icode, // active interval code
	output reg [31:0] out_interval, // active interval value
	output reg [2:0] out_decimals, // trailing decimals
	output reg [31:0] out_net, // gross minus tare
	output reg out_tare_active, // net mode
	output reg out_overload // display blanking request
);
	// ==========================================================
	// configuration registers
	reg [31:0] mode; // range count and interval count
	reg [31:0] icode; // interval codes per range
	reg [31:0] cap_low; // capacity of low range or whole scale
	reg [31:0] cap_mid; // capacity of middle range
	reg [31:0] cap_high; // capacity of high range
	reg [15:0] res; // load-cell resolution in d
	reg [31:0] adapt; // adaptation settings

	// ==========================================================
	// bus state
	reg aw_got; // address held
	reg w_got; // data held
	reg [7:0] awa; // held write address
	reg [31:0] wd; // held write data
	reg [3:0] ws; // held strobes
	wire wr_fire = aw_got && w_got && !s_axi_bvalid;

	// ==========================================================
	// selector state
	reg [1:0] rng; // active range index
	reg [31:0] tare; // stored tare
	reg tare_on; // net mode
	reg tare_refused; // last key press could not tare
	reg [31:0] last_gross; // gross of the latest sample
	reg tk_s1; // key synchroniser, first stage
	reg tk_s2; // key synchroniser, second stage
	reg tk_s3; // key history for edge
	wire key_edge = tk_s2 && !tk_s3;

	// ==========================================================
	// helpers
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer b;
		begin
			wmerge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (st[b]) begin
					wmerge[b*8 +: 8] = nw[b*8 +: 8];
				end
			end
		end
	endfunction

	// trailing decimals drop by one every three codes
	function [2:0] dec_of;
		input [4:0] c;
		begin
			if (c < 5'h03) begin
				dec_of = 3'h4;
			end else if (c < 5'h06) begin
				dec_of = 3'h3;
			end else if (c < 5'h09) begin
				dec_of = 3'h2;
			end else if (c < 5'h0c) begin
				dec_of = 3'h1;
			end else begin
				dec_of = 3'h0;
			end
		end
	endfunction

	// next larger code, clamped at the top of the table
	function [4:0] code_up;
		input [4:0] c;
		input [4:0] n;
		reg [5:0] s;
		begin
			s = {1'b0, c} + {1'b0, n};
			code_up = (s > {1'b0, `SRS_CODE_MAX}) ? `SRS_CODE_MAX : s[4:0];
		end
	endfunction

	// round to nearest multiple of the interval; divider is costly
	// but runs only on range steps and tare
	function [31:0] rnd;
		input [31:0] v;
		input [31:0] iv;
		reg [32:0] s;
		reg [32:0] q;
		reg [65:0] p;
		begin
			s = {1'b0, v} + {2'b00, iv[31:1]};
			q = s / {1'b0, iv};
			p = q * {1'b0, iv};
			rnd = p[31:0];
		end
	endfunction

	// ==========================================================
	// mode decode
	wire [1:0] nr = mode[`SRS_F_NR];
	wire [1:0] ni = mode[`SRS_F_NI];
	// R1: two or three ranges count as multiple range
	wire multi_rng = (nr == `SRS_CNT_TWO) || (nr == `SRS_CNT_THREE);
	// R9: intervals only on a single range scale
	wire multi_iv = !multi_rng && (ni == `SRS_CNT_TWO || ni == `SRS_CNT_THREE);
	wire [1:0] top_rng = multi_rng ? nr - `SRS_CNT_ONE : `SRS_RNG_LOW;
	wire [4:0] c0 = icode[`SRS_F_C0];
	// R13: derived codes in multi-interval mode
	// R15: next larger permitted interval
	wire [4:0] c1 = multi_iv ? code_up(c0, `SRS_CODE_STEP) : icode[`SRS_F_C1];
	wire [4:0] c2 = multi_iv ? code_up(c0, `SRS_CODE_STEP2) : icode[`SRS_F_C2];

	// ==========================================================
	// R17: 1-2-5 interval table with registered read
	wire [95:0] ivs;
	srs_itab u_itab (
		.aclk(aclk),
		.aresetn(aresetn),
		.code({c2, c1, c0}),
		.ival(ivs)
	);
	wire [31:0] iv0 = ivs[31:0];
	wire [31:0] iv1 = ivs[63:32];
	wire [31:0] iv2 = ivs[95:64];
	// R14: smallest range limit from resolution
	wire [47:0] lim0 = iv0 * res;
	// R15: second limit from next interval
	wire [47:0] lim1 = iv1 * res;

	// ==========================================================
	// per-sample decisions
	wire g_neg = gross_weight[31];
	wire [47:0] g48 = {16'h0000, gross_weight};
	wire g_zero = (gross_weight == 32'h00000000);
	reg [31:0] cap_cur; // capacity of active range
	reg [31:0] iv_cur; // interval of active range
	reg [1:0] next_rng; // range after this sample
	reg [31:0] iv_nr; // interval of next_rng
	reg [4:0] c_act; // code shown with this sample
	reg [31:0] iv_act; // interval shown with this sample
	reg [31:0] cap_tot; // top capacity for overload
	reg [39:0] ovl_pad; // overload allowance
	reg [40:0] ovl_lim; // capacity plus allowance

	// combinational range and interval choice
	always @* begin
		cap_cur = cap_low;
		iv_cur = iv0;
		next_rng = rng;
		iv_nr = iv0;
		c_act = c0;
		iv_act = iv0;
		cap_tot = cap_low;
		if (rng == `SRS_RNG_MID) begin
			cap_cur = cap_mid;
			iv_cur = iv1;
		end else if (rng == `SRS_RNG_HIGH) begin
			cap_cur = cap_high;
			iv_cur = iv2;
		end
		if (multi_iv) begin
			// R10: interval follows weight up and down
			if (!g_neg && g48 > lim1 && ni == `SRS_CNT_THREE) begin
				next_rng = `SRS_RNG_HIGH;
			end else if (!g_neg && g48 > lim0) begin
				next_rng = `SRS_RNG_MID;
			end else begin
				next_rng = `SRS_RNG_LOW;
			end
		end else if (multi_rng) begin
			cap_tot = (nr == `SRS_CNT_THREE) ? cap_high : cap_mid;
			if (!tare_on && g_zero) begin
				// R5: gross zero returns to smallest range
				next_rng = `SRS_RNG_LOW;
			end else if (!g_neg && rng < top_rng && gross_weight > cap_cur) begin
				// R2: first sample over limit steps up
				// R19: one step per sample
				next_rng = rng + `SRS_CNT_ONE;
			end
			// R3: no step down while unloading
			// R4: net mode holds range until key clears
		end else begin
			next_rng = `SRS_RNG_LOW;
		end
		if (next_rng == `SRS_RNG_MID) begin
			iv_nr = iv1;
			c_act = c1;
		end else if (next_rng == `SRS_RNG_HIGH) begin
			iv_nr = iv2;
			c_act = c2;
		end
		iv_act = iv_nr;
		if (multi_iv && tare_on) begin
			// R11: tared multi-interval uses smallest interval
			c_act = c0;
			iv_act = iv0;
		end
		// R16: overload above capacity plus allowance in d
		ovl_pad = adapt[`SRS_F_OV] * iv_act;
		ovl_lim = {9'h000, cap_tot} + {1'b0, ovl_pad};
	end

	// ==========================================================
	// tare key synchroniser
	always @(posedge aclk) begin
		if (!aresetn) begin
			tk_s1 <= 1'b0;
			tk_s2 <= 1'b0;
			tk_s3 <= 1'b0;
		end else begin
			tk_s1 <= tare_key;
			tk_s2 <= tk_s1;
			tk_s3 <= tk_s2;
		end
	end

	// ==========================================================
	// selector state and sample outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			rng <= `SRS_RNG_LOW;
			tare <= 32'h00000000;
			tare_on <= 1'b0;
			tare_refused <= 1'b0;
			last_gross <= 32'h00000000;
			out_valid <= 1'b0;
			out_range <= `SRS_RNG_LOW;
			out_icode <= 5'h00;
			out_interval <= 32'h00000000;
			out_decimals <= 3'h0;
			out_net <= 32'h00000000;
			out_tare_active <= 1'b0;
			out_overload <= 1'b0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				last_gross <= gross_weight;
				rng <= next_rng;
				// R6: range change rounds tare to new interval
				if (multi_rng && tare_on && next_rng != rng) begin
					tare <= rnd(tare, iv_nr);
				end
				// R20: range, interval and decimals per sample
				out_range <= next_rng;
				out_icode <= c_act;
				out_interval <= iv_act;
				out_decimals <= dec_of(c_act);
				out_net <= tare_on ? gross_weight - tare : gross_weight;
				out_tare_active <= tare_on;
				out_overload <= !g_neg && ({9'h000, gross_weight} > ovl_lim);
			end
			// a key press wins over a sample in the same cycle
			if (key_edge) begin
				if (tare_on) begin
					// R4: clear tare, then gross and smallest range
					tare_on <= 1'b0;
					tare <= 32'h00000000;
					rng <= `SRS_RNG_LOW;
				end else if (last_gross[31] ||
					(multi_iv && {16'h0000, last_gross} > lim0)) begin
					// R12: tare above smallest range refused
					tare_refused <= 1'b1;
				end else begin
					tare_on <= 1'b1;
					tare_refused <= 1'b0;
					// weight input is not valid between strobes, so the
					// interval comes from the held range, not next_rng
					tare <= rnd(last_gross, multi_iv ? iv0 : iv_cur);
				end
			end
		end
	end

	// ==========================================================
	// axi4-lite slave, write path
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SRS_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awa <= 8'h00;
			wd <= 32'h00000000;
			ws <= 4'h0;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_got <= 1'b1;
				awa <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_got <= 1'b1;
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// status words are read only, so they answer slverr
				case (awa)
				`SRS_A_MODE, `SRS_A_ICODE, `SRS_A_CAPL, `SRS_A_CAPM,
				`SRS_A_CAPH, `SRS_A_RES, `SRS_A_ADAPT:
					s_axi_bresp <= `SRS_RESP_OKAY;
				default:
					s_axi_bresp <= `SRS_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// resolution keeps only its low half of the merged word
	wire [31:0] res_merged = wmerge({16'h0000, res}, wd, ws);

	// configuration storage
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode <= `SRS_MODE_RST;
			icode <= `SRS_ICODE_RST;
			cap_low <= `SRS_CAPL_RST;
			cap_mid <= `SRS_CAPM_RST;
			cap_high <= `SRS_CAPH_RST;
			res <= `SRS_RES_RST;
			// R16: adaptation defaults
			// R18: motion window code 1 means 0.5d
			adapt <= `SRS_ADAPT_RST;
		end else if (wr_fire) begin
			case (awa)
			`SRS_A_MODE: mode <= wmerge(mode, wd, ws);
			`SRS_A_ICODE: icode <= wmerge(icode, wd, ws);
			`SRS_A_CAPL: cap_low <= wmerge(cap_low, wd, ws);
			`SRS_A_CAPM: cap_mid <= wmerge(cap_mid, wd, ws);
			`SRS_A_CAPH: cap_high <= wmerge(cap_high, wd, ws);
			`SRS_A_RES: res <= res_merged[15:0];
			`SRS_A_ADAPT: adapt <= wmerge(adapt, wd, ws);
			default: mode <= mode;
			endcase
		end
	end

	// ==========================================================
	// axi4-lite slave, read path
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SRS_RESP_OKAY;
		end else begin
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SRS_RESP_OKAY;
				case (s_axi_araddr)
				`SRS_A_MODE: s_axi_rdata <= mode;
				`SRS_A_ICODE: s_axi_rdata <= icode;
				`SRS_A_CAPL: s_axi_rdata <= cap_low;
				`SRS_A_CAPM: s_axi_rdata <= cap_mid;
				`SRS_A_CAPH: s_axi_rdata <= cap_high;
				`SRS_A_RES: s_axi_rdata <= {16'h0000, res};
				`SRS_A_ADAPT: s_axi_rdata <= adapt;
				`SRS_A_STAT: s_axi_rdata <= {19'h00000, out_overload,
					tare_refused, tare_on, rng, out_decimals, out_icode};
				`SRS_A_TARE: s_axi_rdata <= tare;
				`SRS_A_NET: s_axi_rdata <= out_net;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SRS_RESP_SLVERR;
				end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// >>> srs_chk_properties.sv
// Purpose: port-level checks of the range selector
// Assumes: one clock, aresetn synchronous and active low
// Notes: bound to srs_top, sees only its ports
`timescale 1ns/100ps

module srs_chk (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire sample_valid,
	input wire [31:0] gross_weight,
	input wire out_valid,
	input wire [1:0] out_range,
	input wire [4:0] out_icode,
	input wire [31:0] out_interval,
	input wire [2:0] out_decimals,
	input wire [31:0] out_net,
	input wire out_tare_active,
	input wire out_overload
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// helper decode of the shown interval code
	reg [31:0] exp_ival; // value the code stands for
	reg [2:0] exp_dec; // decimals the code implies
	integer k; // decade counter
	// 1-2-5 mantissa, one decade per three codes
	always @* begin
		exp_ival = (out_icode % 3 == 0) ? 32'h1 :
			(out_icode % 3 == 1) ? 32'h2 : 32'h5;
		for (k = 3; k <= out_icode; k = k + 3)
			exp_ival = exp_ival * 32'ha;
		exp_dec = (out_icode > 5'h0b) ? 3'h0 : 3'(3'h4 - out_icode / 5'h3);
	end
	// ==========================================
	// sample path
	// answer follows sample
	property p_answer; sample_valid |=> out_valid; endproperty
	a_answer: assert property (p_answer) else $error("no result after sample");
	property p_quiet; !sample_valid |=> !out_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("result without sample");
	property p_hold;
		!out_valid |-> $stable(out_net) && $stable(out_interval) &&
			$stable(out_overload);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved between samples");
	property p_ival; out_valid |-> out_interval == exp_ival; endproperty
	a_ival: assert property (p_ival) else $error("interval does not match code");
	property p_dec; out_valid |-> out_decimals == exp_dec; endproperty
	a_dec: assert property (p_dec) else $error("decimals do not match code");
	property p_net;
		out_valid && !out_tare_active |-> out_net == $past(gross_weight);
	endproperty
	a_net: assert property (p_net) else $error("gross weight not passed on");
	property p_zero;
		out_valid && !out_tare_active && $past(gross_weight) == 32'h0
			|-> out_range == 2'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("zero load kept higher range");
	// ==========================================
	// register bus
	property p_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write response late");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read data late");
	property p_unmap;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
	property p_ro;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h1c
			|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2);
	endproperty
	a_ro: assert property (p_ro) else $error("status write not refused");
endmodule

bind srs_top srs_chk srs_chk_i (.*);

// >>> srs_wsrc.sv
// Purpose: weight path and tare key in front of the selector
// Assumes: bench asks for samples and key presses
// Notes: weight is scrambled outside its strobe
`timescale 1ns/100ps

module srs_wsrc (
	input wire aclk,
	input wire go, // bench asks for one sample
	input wire [31:0] wval, // weight of that sample
	input wire key, // bench holds the key down
	output reg sample_valid = 1'b0,
	output reg [31:0] gross_weight = 32'h0,
	output reg tare_key = 1'b0
);
	// one strobe per request; weight changes each idle cycle so a
	// selector that samples off the strobe sees rubbish
	always @(posedge aclk) begin
		sample_valid <= go;
		gross_weight <= go ? wval : ~gross_weight;
		tare_key <= key;
	end
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench of the range selector
// Assumes: 10 MHz clock, bus and samples driven on rising edges
// Notes: expected results queue up, a monitor pops them
`timescale 1ns/100ps
`include "srs_map.vh"

module tb_top;
	reg aclk = 1'b0, aresetn = 1'b0, go = 1'b0, key = 1'b0;
	reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	reg [31:0] s_axi_wdata = 32'h0, wval = 32'h0, rd, wv, t1, t2, t3;
	reg [3:0] s_axi_wstrb = 4'hf; // whole words only
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg [1:0] rr;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, sample_valid, tare_key, out_valid;
	wire out_tare_active, out_overload;
	wire [1:0] s_axi_bresp, s_axi_rresp, out_range;
	wire [31:0] s_axi_rdata, gross_weight, out_interval, out_net;
	wire [4:0] out_icode;
	wire [2:0] out_decimals;
	integer error_cnt = 0, comparisons = 0, seed = 67, i;
	reg [40:0] expq [$]; // range, code, net, tare, overload
	reg [40:0] e;
	reg [223:0] rstv = {`SRS_MODE_RST, `SRS_ICODE_RST, `SRS_CAPL_RST,
		`SRS_CAPM_RST, `SRS_CAPH_RST, 16'h0, `SRS_RES_RST, `SRS_ADAPT_RST};

	always #50 aclk = ~aclk;
	srs_top srs_top_i (.*);
	srs_wsrc srs_wsrc_i (.*);

	// ==========================================
	// compare, verdict, expectations
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("mismatches %0d of %0d", error_cnt, comparisons);
			if (error_cnt == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task hang;
		begin
			error_cnt = error_cnt + 1;
			complete_run;
		end
	endtask
	// 1-2-5 series, one decade per three codes
	function [31:0] ivl(input [4:0] c);
		integer k;
		begin
			ivl = (c % 3 == 0) ? 32'h1 : (c % 3 == 1) ? 32'h2 : 32'h5;
			for (k = 3; k <= c; k = k + 3)
				ivl = ivl * 32'ha;
		end
	endfunction
	function [31:0] dcm(input [4:0] c);
		dcm = (c > 5'h0b) ? 32'h0 : 32'h4 - c / 5'h3;
	endfunction

	// ==========================================
	// bus master; bready held up so the answer ends the wait
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		integer n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid !== 1'b1) hang;
			chk(s_axi_bresp, er);
			s_axi_bready <= 1'b0;
			// new settings need two cycles to reach the selector
			repeat (3) @(posedge aclk);
		end
	endtask
	task rdr(input [7:0] a);
		integer n;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid !== 1'b1) hang;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	// ==========================================
	// samples and key
	task smp(input [31:0] g, input [1:0] r, input [4:0] c,
		input [31:0] net, input t, input o);
		begin
			expq.push_back({r, c, net, t, o});
			@(posedge aclk);
			go <= 1'b1;
			wval <= g;
			@(posedge aclk);
			go <= 1'b0;
		end
	endtask
	task press;
		begin
			@(posedge aclk);
			key <= 1'b1;
			repeat (3) @(posedge aclk);
			key <= 1'b0;
			repeat (8) @(posedge aclk);
		end
	endtask
	// monitor: each result against the oldest note
	always @(posedge aclk) begin
		if (out_valid === 1'b1) begin
			if (expq.size() == 0)
				chk(32'h1, 32'h0);
			else begin
				e = expq.pop_front();
				chk(out_range, e[40:39]);
				chk(out_icode, e[38:34]);
				chk(out_interval, ivl(e[38:34]));
				chk(out_decimals, dcm(e[38:34]));
				chk(out_net, e[33:2]);
				chk(out_tare_active, e[1]);
				chk(out_overload, e[0]);
			end
		end
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		hang;
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (i = 0; i < 7; i = i + 1) begin
			rdr(8'(i * 4));
			chk(rd, rstv[223 - 32 * i -: 32]);
		end
		rdr(8'h28);
		chk(rr, `SRS_RESP_SLVERR);
		chk(rd, 32'h0);
		wr(`SRS_A_STAT, 32'h0, `SRS_RESP_SLVERR);
		wr(8'h30, 32'h0, `SRS_RESP_SLVERR);
		// default single range, random loads below capacity
		for (i = 0; i < 8; i = i + 1) begin
			wv = {$random(seed)} % `SRS_CAPL_RST;
			smp(wv, 2'h0, 5'h0b, wv, 1'b0, 1'b0);
		end
		// triple range, equal decimals, 3000d each
		wr(`SRS_A_MODE, 32'h3, `SRS_RESP_OKAY);
		wr(`SRS_A_ICODE, 32'h000b0a09, `SRS_RESP_OKAY);
		wr(`SRS_A_CAPL, 32'h002dc6c0, `SRS_RESP_OKAY);
		wr(`SRS_A_CAPM, 32'h005b8d80, `SRS_RESP_OKAY);
		wr(`SRS_A_CAPH, 32'h00e4e1c0, `SRS_RESP_OKAY);
		t1 = 32'h0023cc10;
		t2 = t1 - 32'h3e8;
		smp(32'h0, 2'h0, 5'h09, 32'h0, 1'b0, 1'b0);
		smp(32'h0023ccd8, 2'h0, 5'h09, 32'h0023ccd8, 1'b0, 1'b0);
		press;
		smp(32'h0023ccd8, 2'h0, 5'h09, 32'hc8, 1'b1, 1'b0);
		// one range per sample, tare rounded on each step
		smp(32'h00895440, 2'h1, 5'h0a, 32'h00895440 - t1, 1'b1, 1'b0);
		smp(32'h00895440, 2'h2, 5'h0b, 32'h00895440 - t1, 1'b1, 1'b0);
		smp(32'h00895440, 2'h2, 5'h0b, 32'h00895440 - t2, 1'b1, 1'b0);
		rdr(`SRS_A_TARE);
		chk(rd, t2);
		smp(32'h0, 2'h2, 5'h0b, 32'h0 - t2, 1'b1, 1'b0);
		press;
		smp(32'h0, 2'h0, 5'h09, 32'h0, 1'b0, 1'b0);
		smp(32'h006acfc0, 2'h1, 5'h0a, 32'h006acfc0, 1'b0, 1'b0);
		smp(32'h006acfc0, 2'h2, 5'h0b, 32'h006acfc0, 1'b0, 1'b0);
		wv = 32'h00e4e1c0 + 32'h0000afc8;
		smp(wv, 2'h2, 5'h0b, wv, 1'b0, 1'b0);
		smp(wv + 32'h1, 2'h2, 5'h0b, wv + 32'h1, 1'b0, 1'b1);
		smp(32'h3e8, 2'h2, 5'h0b, 32'h3e8, 1'b0, 1'b0);
		smp(32'h0, 2'h0, 5'h09, 32'h0, 1'b0, 1'b0);
		// three intervals, upper codes must be ignored
		wr(`SRS_A_MODE, 32'hd, `SRS_RESP_OKAY);
		wr(`SRS_A_ICODE, 32'h0011110b, `SRS_RESP_OKAY);
		wr(`SRS_A_CAPL, `SRS_CAPH_RST, `SRS_RESP_OKAY);
		wv = `SRS_CAPL_RST;
		smp(wv, 2'h0, 5'h0b, wv, 1'b0, 1'b0);
		smp(wv + 32'h1, 2'h1, 5'h0c, wv + 32'h1, 1'b0, 1'b0);
		wv = `SRS_CAPM_RST + 32'h1;
		smp(wv, 2'h2, 5'h0d, wv, 1'b0, 1'b0);
		smp(32'h01312d00, 2'h1, 5'h0c, 32'h01312d00, 1'b0, 1'b0);
		smp(32'h64, 2'h0, 5'h0b, 32'h64, 1'b0, 1'b0);
		wv = `SRS_CAPH_RST + 32'h0002bf20;
		smp(wv, 2'h2, 5'h0d, wv, 1'b0, 1'b0);
		smp(wv + 32'h1, 2'h2, 5'h0d, wv + 32'h1, 1'b0, 1'b1);
		// tare above the first interval range is refused
		smp(32'h01312d00, 2'h1, 5'h0c, 32'h01312d00, 1'b0, 1'b0);
		press;
		rdr(`SRS_A_STAT);
		chk(rd[11:10], 2'h2);
		t3 = 32'h0012d838;
		smp(32'h0012d687, 2'h0, 5'h0b, 32'h0012d687, 1'b0, 1'b0);
		press;
		rdr(`SRS_A_TARE);
		chk(rd, t3);
		smp(32'h01312d00, 2'h1, 5'h0b, 32'h01312d00 - t3, 1'b1, 1'b0);
		// two intervals: no third range however heavy
		wr(`SRS_A_MODE, 32'h9, `SRS_RESP_OKAY);
		smp(32'h02625a00, 2'h1, 5'h0b, 32'h02625a00 - t3, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		chk(expq.size(), 32'h0);
		complete_run;
	end
endmodule
